// ### hdl/flc_pkg.sv
package flc_pkg;

	// lock bit byte
	localparam int          LOCK_LOW_BIT       = 0;
	localparam int          LOCK_HIGH_BIT      = 1;
	localparam logic [1:0]  LOCK_RST           = 2'h3;
	localparam logic [5:0]  LOCK_UNUSED_READ   = 6'h3f;
	localparam logic [1:0]  LOCK_MODE1         = 2'h3;
	localparam logic [1:0]  LOCK_MODE2         = 2'h2;
	localparam logic [1:0]  LOCK_MODE3         = 2'h0;

	// fuse high byte
	localparam int          SELF_PROG_EN_BIT   = 4;
	localparam int          DEBUG_LINK_EN_BIT  = 3;
	localparam int          BROWNOUT_HI_BIT    = 2;
	localparam int          BROWNOUT_LO_BIT    = 1;
	localparam int          EXT_RESET_DIS_BIT  = 0;
	localparam logic [7:0]  FUSE_HIGH_UNUSED   = 8'he0;
	localparam logic [7:0]  FUSE_HIGH_RST      = 8'hff;

	// fuse low byte
	localparam int          SERIAL_PROG_EN_BIT = 7;
	localparam int          EEPROM_PRESERVE_BIT = 6;
	localparam int          WATCHDOG_ON_BIT    = 5;
	localparam int          CLOCK_DIV8_BIT     = 4;
	localparam int          STARTUP_SEL_HI_BIT = 3;
	localparam int          STARTUP_SEL_LO_BIT = 2;
	localparam int          CLOCK_SRC_HI_BIT   = 1;
	localparam int          CLOCK_SRC_LO_BIT   = 0;
	localparam logic [7:0]  FUSE_LOW_RST       = 8'h6a;
	localparam logic [1:0]  CLOCK_SRC_RC_9M6   = 2'h2;

	// firmware fuse/lock read pointers
	localparam logic [15:0] FW_PTR_FUSE_LOW    = 16'h0000;
	localparam logic [15:0] FW_PTR_LOCK        = 16'h0001;
	localparam logic [15:0] FW_PTR_FUSE_HIGH   = 16'h0003;

	// read selector shared by firmware and programmer
	localparam logic [1:0]  SEL_FUSE_LOW       = 2'h0;
	localparam logic [1:0]  SEL_LOCK           = 2'h1;
	localparam logic [1:0]  SEL_FUSE_HIGH      = 2'h3;

	// signature space
	localparam logic [1:0]  SIG_ADDR_0         = 2'h0;
	localparam logic [1:0]  SIG_ADDR_1         = 2'h1;
	localparam logic [1:0]  SIG_ADDR_2         = 2'h2;
	localparam logic [1:0]  CAL_ADDR_9M6       = 2'h0;
	localparam logic [1:0]  CAL_ADDR_4M8       = 2'h1;

	// programmer command codes
	localparam logic [2:0]  CMD_WR_LOCK        = 3'h0;
	localparam logic [2:0]  CMD_WR_FUSE_LOW    = 3'h1;
	localparam logic [2:0]  CMD_WR_FUSE_HIGH   = 3'h2;
	localparam logic [2:0]  CMD_CHIP_ERASE     = 3'h3;
	localparam logic [2:0]  CMD_RD_FUSE_LOCK   = 3'h4;
	localparam logic [2:0]  CMD_RD_SIGNATURE   = 3'h5;

	// memory geometry
	localparam int          FLASH_PC_W         = 9;
	localparam int          FLASH_WORD_W       = 4;
	localparam int          EEPROM_ADDR_W      = 6;
	localparam int          EEPROM_BYTE_W      = 2;

endpackage

// ### hdl/flc_rst_sync.sv
`timescale 1ns/100ps
module flc_rst_sync
(
	input  wire logic clk_in,
	input  wire logic nrst_in,
	output logic      nrst_sync_out
);
	logic stage1_r;

	// release only after two edges; stage1 feeds nothing else
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			stage1_r      <= 1'b0;
			nrst_sync_out <= 1'b0;
		end
		else
		begin
			stage1_r      <= 1'b1;
			nrst_sync_out <= stage1_r;
		end
	end
endmodule

// ### hdl/flc_geom.sv
`timescale 1ns/100ps
module flc_geom
	import flc_pkg::*;
#(
	parameter int PC_W    = FLASH_PC_W,
	parameter int WORD_W  = FLASH_WORD_W,
	parameter int EEA_W   = EEPROM_ADDR_W,
	parameter int EBYTE_W = EEPROM_BYTE_W
)
(
	input  wire logic               clk_in,
	input  wire logic               nrst_in,
	input  wire logic [PC_W-1:0]    pc_in,
	input  wire logic [EEA_W-1:0]   eeprom_addr_in,
	output logic [WORD_W-1:0]       flash_word_index_out,
	output logic [PC_W-WORD_W-1:0]  flash_page_index_out,
	output logic [EBYTE_W-1:0]      eeprom_byte_out,
	output logic [EEA_W-EBYTE_W-1:0] eeprom_page_out
);
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			flash_word_index_out <= '0;
			flash_page_index_out <= '0;
			eeprom_byte_out      <= '0;
			eeprom_page_out      <= '0;
		end
		else
		begin
			flash_word_index_out <= pc_in[WORD_W-1:0]; // RULE20
			flash_page_index_out <= pc_in[PC_W-1:WORD_W]; // RULE20
			eeprom_byte_out      <= eeprom_addr_in[EBYTE_W-1:0]; // RULE21
			eeprom_page_out      <= eeprom_addr_in[EEA_W-1:EBYTE_W]; // RULE21
		end
	end
endmodule

// ### hdl/flc_fuse_lock_unit.sv
// Functional notes
// RULE1: two lock bits, raised only by erase
// RULE2: debug fuse keeps program memory readable
// RULE3: mode 1 imposes no locking
// RULE4: mode 2 blocks writes, fuses, debug
// RULE5: mode 3 also blocks memory verification
// RULE6: programmed fuse reads zero, else one
// RULE7: high fuse byte field layout, default ones
// RULE8: low fuse byte field layout and defaults
// RULE9: serial mode cannot change serial-enable fuse
// RULE10: watchdog-always-on disables watchdog interrupt
// RULE11: default clock source is 9.6 MHz RC
// RULE12: programmed low lock bit refuses fuse writes
// RULE13: chip erase leaves fuses unchanged
// RULE14: fuses latched on programming entry, applied after
// RULE15: eeprom preserve fuse acts immediately
// RULE16: fuses latched at power-up in normal mode
// RULE17: every reset loads 9.6 MHz calibration byte
// RULE18: firmware loads 4.8 MHz calibration itself
// RULE19: three-byte signature readable regardless of lock
// RULE20: flash 32 pages of 16 words
// RULE21: eeprom 16 pages of 4 bytes
// RULE22: firmware pointer 1 returns lock bits
// RULE23: firmware pointer 0 returns low fuses
// RULE24: firmware pointer 3 returns high fuses
// RULE25: normal-mode decode uses latched copies
`timescale 1ns/100ps
module flc_fuse_lock_unit
	import flc_pkg::*;
#(
	parameter logic [7:0] SIG_BYTE0 = 8'h5a, // arbitrary value
	parameter logic [7:0] SIG_BYTE1 = 8'h01, // arbitrary value
	parameter logic [7:0] SIG_BYTE2 = 8'h02, // arbitrary value
	parameter logic [7:0] CAL_9M6   = 8'h80,
	parameter logic [7:0] CAL_4M8   = 8'h80
)
(
	input  wire logic        REF_CLK_IN,
	input  wire logic        NRST_IN,
	input  wire logic        SYS_RESET_IN,
	input  wire logic        PROG_MODE_IN,
	input  wire logic        PROG_HV_IN,
	input  wire logic        PROG_CMD_VALID_IN,
	input  wire logic [2:0]  PROG_CMD_IN,
	input  wire logic [1:0]  PROG_ADDR_IN,
	input  wire logic [7:0]  PROG_DATA_IN,
	output logic [7:0]       PROG_RDATA_OUT,
	output logic             PROG_RVALID_OUT,
	output logic             PROG_REFUSED_OUT,
	output logic             ERASE_FLASH_OUT,
	output logic             ERASE_EEPROM_OUT,
	output logic             PROG_MEM_WR_OK_OUT,
	output logic             PROG_MEM_VERIFY_OK_OUT,
	input  wire logic        FW_RD_IN,
	input  wire logic [15:0] FW_PTR_IN,
	output logic [7:0]       FW_RDATA_OUT,
	output logic             FW_RVALID_OUT,
	input  wire logic        OSC_CAL_WE_IN,
	input  wire logic [7:0]  OSC_CAL_WDATA_IN,
	output logic [7:0]       OSC_CAL_OUT,
	output logic             SELF_PROG_EN_OUT,
	output logic             DEBUG_LINK_EN_OUT,
	output logic             DEBUG_PM_READ_OUT,
	output logic [1:0]       BROWNOUT_LEVEL_OUT,
	output logic             EXT_RESET_DIS_OUT,
	output logic             SERIAL_PROG_EN_OUT,
	output logic             EEPROM_PRESERVE_OUT,
	output logic             WDT_ALWAYS_ON_OUT,
	output logic             WDT_IRQ_EN_OUT,
	output logic             CLOCK_DIV8_OUT,
	output logic [1:0]       STARTUP_SEL_OUT,
	output logic [1:0]       CLOCK_SRC_OUT,
	output logic             CLK_RC_9M6_OUT,
	input  wire logic [8:0]  FLASH_PC_IN,
	input  wire logic [5:0]  EEPROM_ADDR_IN,
	output logic [3:0]       FLASH_WORD_INDEX_OUT,
	output logic [4:0]       FLASH_PAGE_INDEX_OUT,
	output logic [1:0]       EEPROM_BYTE_OUT,
	output logic [3:0]       EEPROM_PAGE_OUT
);
	logic       rst_n;
	logic [1:0] nv_lock_r;
	logic [7:0] nv_fuse_low_r;
	logic [7:0] nv_fuse_high_r;
	logic [1:0] lat_lock_r;
	logic [7:0] lat_fuse_low_r;
	logic [7:0] lat_fuse_high_r;
	logic       prog_prev_r;
	logic       pu_done_r;
	logic [1:0] nv_lock_nxt;
	logic [7:0] nv_fuse_low_nxt;
	logic [7:0] nv_fuse_high_nxt;
	logic [7:0] osc_cal_r;

	// reads lock, low and high fuse bytes by selector
	function automatic logic [7:0] pick_byte(input logic [1:0] sel, input logic [1:0] lock,
		input logic [7:0] flo, input logic [7:0] fhi);
		logic [7:0] res;
		res = 8'h00;
		unique case (sel)
			SEL_FUSE_LOW:  res = flo; // RULE23
			SEL_LOCK:      res = {LOCK_UNUSED_READ, lock}; // RULE22
			SEL_FUSE_HIGH: res = fhi; // RULE24
			default:       res = 8'h00;
		endcase
		return res;
	endfunction

	flc_rst_sync u_rst_sync
	(
		.clk_in        (REF_CLK_IN),
		.nrst_in       (NRST_IN),
		.nrst_sync_out (rst_n)
	);

	flc_geom u_geom
	(
		.clk_in               (REF_CLK_IN),
		.nrst_in              (rst_n),
		.pc_in                (FLASH_PC_IN),
		.eeprom_addr_in       (EEPROM_ADDR_IN),
		.flash_word_index_out (FLASH_WORD_INDEX_OUT),
		.flash_page_index_out (FLASH_PAGE_INDEX_OUT),
		.eeprom_byte_out      (EEPROM_BYTE_OUT),
		.eeprom_page_out      (EEPROM_PAGE_OUT)
	);

	// command decode
	wire cmd_live     = PROG_CMD_VALID_IN & PROG_MODE_IN;
	wire fuse_locked  = ~nv_lock_r[LOCK_LOW_BIT]; // RULE12
	wire is_fuse_wr   = (PROG_CMD_IN == CMD_WR_FUSE_LOW) | (PROG_CMD_IN == CMD_WR_FUSE_HIGH);
	wire known_cmd    = (PROG_CMD_IN <= CMD_RD_SIGNATURE);
	wire refuse       = PROG_CMD_VALID_IN & (~PROG_MODE_IN | ~known_cmd | (is_fuse_wr & fuse_locked));
	wire go           = cmd_live & ~refuse;
	wire lock_wr_go   = go & (PROG_CMD_IN == CMD_WR_LOCK);
	wire low_wr_go    = go & (PROG_CMD_IN == CMD_WR_FUSE_LOW);
	wire high_wr_go   = go & (PROG_CMD_IN == CMD_WR_FUSE_HIGH);
	wire erase_go     = go & (PROG_CMD_IN == CMD_CHIP_ERASE);
	wire fuse_rd_go   = go & (PROG_CMD_IN == CMD_RD_FUSE_LOCK);
	wire sig_rd_go    = go & (PROG_CMD_IN == CMD_RD_SIGNATURE);

	// signature answers whatever the lock state
	wire [7:0] sig_byte = (PROG_ADDR_IN == SIG_ADDR_0) ? SIG_BYTE0 :
		(PROG_ADDR_IN == SIG_ADDR_1) ? SIG_BYTE1 :
		(PROG_ADDR_IN == SIG_ADDR_2) ? SIG_BYTE2 : 8'h00; // RULE19
	wire [7:0] prog_rd_byte = sig_rd_go ? sig_byte :
		pick_byte(PROG_ADDR_IN, nv_lock_r, nv_fuse_low_r, nv_fuse_high_r);

	// serial mode keeps the stored serial-enable bit
	wire [7:0] low_wr_data = PROG_HV_IN ? PROG_DATA_IN :
		{nv_fuse_low_r[SERIAL_PROG_EN_BIT], PROG_DATA_IN[6:0]}; // RULE9

	// lock bits only move toward programmed; erase is the way back
	assign nv_lock_nxt = erase_go ? LOCK_RST :
		lock_wr_go ? (nv_lock_r & PROG_DATA_IN[1:0]) : nv_lock_r; // RULE1
	// erase does not touch fuses
	assign nv_fuse_low_nxt  = low_wr_go ? low_wr_data : nv_fuse_low_r; // RULE13
	assign nv_fuse_high_nxt = high_wr_go ? (PROG_DATA_IN | FUSE_HIGH_UNUSED) : nv_fuse_high_r; // RULE7

	// latch at power-up in normal mode and at each programming entry/exit
	wire latch_ev = (~pu_done_r & ~PROG_MODE_IN) | (PROG_MODE_IN ^ prog_prev_r); // RULE14 RULE16

	// cells model a blank part after power-on; a real array would persist
	always_ff @(posedge REF_CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nv_lock_r      <= LOCK_RST;
			nv_fuse_low_r  <= FUSE_LOW_RST; // RULE8
			nv_fuse_high_r <= FUSE_HIGH_RST; // RULE7
		end
		else
		begin
			nv_lock_r      <= nv_lock_nxt;
			nv_fuse_low_r  <= nv_fuse_low_nxt;
			nv_fuse_high_r <= nv_fuse_high_nxt;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lat_lock_r      <= LOCK_RST;
			lat_fuse_low_r  <= FUSE_LOW_RST;
			lat_fuse_high_r <= FUSE_HIGH_RST;
			prog_prev_r     <= 1'b0;
			pu_done_r       <= 1'b0;
		end
		else
		begin
			prog_prev_r <= PROG_MODE_IN;
			pu_done_r   <= 1'b1;
			if (latch_ev)
			begin
				lat_lock_r      <= nv_lock_r; // RULE14
				lat_fuse_low_r  <= nv_fuse_low_r; // RULE16
				lat_fuse_high_r <= nv_fuse_high_r;
			end
		end
	end

	// answers and erase pulses
	always_ff @(posedge REF_CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			PROG_RDATA_OUT   <= 8'h00;
			PROG_RVALID_OUT  <= 1'b0;
			PROG_REFUSED_OUT <= 1'b0;
			ERASE_FLASH_OUT  <= 1'b0;
			ERASE_EEPROM_OUT <= 1'b0;
			FW_RDATA_OUT     <= 8'h00;
			FW_RVALID_OUT    <= 1'b0;
		end
		else
		begin
			PROG_RVALID_OUT  <= fuse_rd_go | sig_rd_go;
			PROG_REFUSED_OUT <= refuse; // RULE12
			ERASE_FLASH_OUT  <= erase_go;
			ERASE_EEPROM_OUT <= erase_go & nv_fuse_low_r[EEPROM_PRESERVE_BIT]; // RULE15
			FW_RVALID_OUT    <= FW_RD_IN;
			if (fuse_rd_go | sig_rd_go)
				PROG_RDATA_OUT <= prog_rd_byte; // RULE6
			if (FW_RD_IN)
				FW_RDATA_OUT <= (FW_PTR_IN[15:2] == FW_PTR_FUSE_LOW[15:2]) ?
					pick_byte(FW_PTR_IN[1:0], nv_lock_r, nv_fuse_low_r, nv_fuse_high_r) :
					8'h00; // RULE22 RULE23 RULE24
		end
	end

	// calibration: hardware only ever loads the 9.6 MHz byte
	always_ff @(posedge REF_CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
			osc_cal_r <= CAL_9M6; // RULE17
		else if (SYS_RESET_IN)
			osc_cal_r <= CAL_9M6; // RULE17
		else if (OSC_CAL_WE_IN)
			osc_cal_r <= OSC_CAL_WDATA_IN; // RULE18
	end
	assign OSC_CAL_OUT = osc_cal_r;

	// programming gates follow the live lock cells so new locks bite at once
	wire lock_mode1 = (nv_lock_r == LOCK_MODE1); // RULE3
	assign PROG_MEM_WR_OK_OUT     = PROG_MODE_IN & lock_mode1; // RULE4
	assign PROG_MEM_VERIFY_OK_OUT = PROG_MODE_IN & nv_lock_r[LOCK_LOW_BIT] |
		PROG_MODE_IN & (nv_lock_r == LOCK_MODE2); // RULE5

	// normal-mode functions from latched copies, except eeprom preserve from the live cell; programmed means zero
	wire lat_mode1 = (lat_lock_r == LOCK_MODE1);
	assign SELF_PROG_EN_OUT    = ~lat_fuse_high_r[SELF_PROG_EN_BIT]; // RULE25
	// link closes under lock, yet program readout stays open with the fuse
	assign DEBUG_LINK_EN_OUT   = ~lat_fuse_high_r[DEBUG_LINK_EN_BIT] & lat_mode1; // RULE4 RULE5
	assign DEBUG_PM_READ_OUT   = ~lat_fuse_high_r[DEBUG_LINK_EN_BIT]; // RULE2
	assign BROWNOUT_LEVEL_OUT  = {lat_fuse_high_r[BROWNOUT_HI_BIT], lat_fuse_high_r[BROWNOUT_LO_BIT]};
	assign EXT_RESET_DIS_OUT   = ~lat_fuse_high_r[EXT_RESET_DIS_BIT]; // RULE6
	assign SERIAL_PROG_EN_OUT  = ~lat_fuse_low_r[SERIAL_PROG_EN_BIT];
	assign EEPROM_PRESERVE_OUT = ~nv_fuse_low_r[EEPROM_PRESERVE_BIT]; // RULE15
	assign WDT_ALWAYS_ON_OUT   = ~lat_fuse_low_r[WATCHDOG_ON_BIT];
	assign WDT_IRQ_EN_OUT      = lat_fuse_low_r[WATCHDOG_ON_BIT]; // RULE10
	assign CLOCK_DIV8_OUT      = ~lat_fuse_low_r[CLOCK_DIV8_BIT];
	assign STARTUP_SEL_OUT     = {lat_fuse_low_r[STARTUP_SEL_HI_BIT],
		lat_fuse_low_r[STARTUP_SEL_LO_BIT]};
	assign CLOCK_SRC_OUT       = {lat_fuse_low_r[CLOCK_SRC_HI_BIT], lat_fuse_low_r[CLOCK_SRC_LO_BIT]};
	assign CLK_RC_9M6_OUT      = (CLOCK_SRC_OUT == CLOCK_SRC_RC_9M6); // RULE11

	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!rst_n);

	chk_lock_raise_erase: assert property ( // RULE1
		((nv_lock_r & ~$past(nv_lock_r)) != 2'h0) |-> $past(erase_go))
		else $error("lock bit returned to one without erase");

	chk_debug_readout: assert property ( // RULE2
		(!lat_fuse_high_r[DEBUG_LINK_EN_BIT] && lat_lock_r == LOCK_MODE3) |->
		(DEBUG_PM_READ_OUT && !DEBUG_LINK_EN_OUT))
		else $error("debug readout wrong under lock bits");

	chk_mode1_open: assert property ( // RULE3
		(PROG_MODE_IN && nv_lock_r == LOCK_MODE1) |-> (PROG_MEM_WR_OK_OUT && PROG_MEM_VERIFY_OK_OUT))
		else $error("mode 1 blocks memory access");

	chk_mode2_block: assert property ( // RULE4
		(PROG_MODE_IN && nv_lock_r == LOCK_MODE2) |-> (!PROG_MEM_WR_OK_OUT && PROG_MEM_VERIFY_OK_OUT))
		else $error("mode 2 gating wrong");

	chk_mode3_block: assert property ( // RULE5
		(nv_lock_r == LOCK_MODE3) |-> (!PROG_MEM_WR_OK_OUT && !PROG_MEM_VERIFY_OK_OUT))
		else $error("mode 3 leaves memory open");

	chk_fuse_refused: assert property ( // RULE12
		(cmd_live && is_fuse_wr && fuse_locked) |=>
		(PROG_REFUSED_OUT && $stable(nv_fuse_low_r) && $stable(nv_fuse_high_r)))
		else $error("fuse write accepted while locked");

	chk_serial_keep: assert property ( // RULE9
		(low_wr_go && !PROG_HV_IN) |=>
		(nv_fuse_low_r[SERIAL_PROG_EN_BIT] == $past(nv_fuse_low_r[SERIAL_PROG_EN_BIT])))
		else $error("serial mode changed serial enable fuse");

	chk_erase_fuses: assert property ( // RULE13
		erase_go |=> ($stable(nv_fuse_low_r) && $stable(nv_fuse_high_r) && nv_lock_r == LOCK_RST))
		else $error("erase disturbed fuses or kept locks");

	chk_latch_hold: assert property ( // RULE14
		(PROG_MODE_IN && prog_prev_r) |=> ($stable(lat_fuse_low_r) && $stable(lat_fuse_high_r)))
		else $error("latched fuses moved inside session");

	chk_preserve_live: assert property ( // RULE15
		low_wr_go |=> (EEPROM_PRESERVE_OUT == !$past(PROG_DATA_IN[EEPROM_PRESERVE_BIT])))
		else $error("eeprom preserve not immediate");

	chk_cal_reload: assert property ( // RULE17
		SYS_RESET_IN |=> (OSC_CAL_OUT == CAL_9M6))
		else $error("calibration not loaded at reset");

	chk_fw_lock_read: assert property ( // RULE22
		(FW_RD_IN && FW_PTR_IN == FW_PTR_LOCK) |=>
		(FW_RVALID_OUT && FW_RDATA_OUT[1:0] == $past(nv_lock_r)))
		else $error("firmware lock read wrong");

	chk_sig_read: assert property ( // RULE19
		(sig_rd_go && PROG_ADDR_IN == SIG_ADDR_0) |=> (PROG_RVALID_OUT && PROG_RDATA_OUT == SIG_BYTE0))
		else $error("signature byte wrong");

	chk_mode2_debug: assert property ( // RULE4
		(lat_lock_r == LOCK_MODE2) |-> !DEBUG_LINK_EN_OUT)
		else $error("debug link open in mode 2");

	chk_erase_eeprom: assert property ( // RULE15
		erase_go |=> (ERASE_FLASH_OUT && (ERASE_EEPROM_OUT != $past(EEPROM_PRESERVE_OUT))))
		else $error("eeprom erase ignores preserve fuse");

	chk_power_latch: assert property ( // RULE16
		(!pu_done_r && !PROG_MODE_IN) |=>
		(lat_fuse_low_r == $past(nv_fuse_low_r) && lat_fuse_high_r == $past(nv_fuse_high_r)))
		else $error("fuses not latched at power-up");

	chk_entry_latch: assert property ( // RULE14
		(PROG_MODE_IN && !prog_prev_r) |=>
		(lat_lock_r == $past(nv_lock_r) && lat_fuse_high_r == $past(nv_fuse_high_r)))
		else $error("fuses not latched on session entry");

	chk_fw_high_read: assert property ( // RULE24
		(FW_RD_IN && FW_PTR_IN == FW_PTR_FUSE_HIGH) |=>
		(FW_RVALID_OUT && FW_RDATA_OUT == $past(nv_fuse_high_r)))
		else $error("firmware high fuse read wrong");

endmodule

// ### tb/flc_prog_model.sv
`timescale 1ns/100ps
module flc_prog_model
(
	input  wire logic        clk_in,
	input  wire logic [7:0]  rdata_in,
	input  wire logic        rvalid_in,
	input  wire logic        refused_in,
	input  wire logic [7:0]  fw_rdata_in,
	input  wire logic        fw_rvalid_in,
	output logic             mode_out,
	output logic             hv_out,
	output logic             valid_out,
	output logic [2:0]       cmd_out,
	output logic [1:0]       addr_out,
	output logic [7:0]       data_out,
	output logic             fw_rd_out,
	output logic [15:0]      fw_ptr_out
);
	initial
	begin
		mode_out   = 1'b0;
		hv_out     = 1'b0;
		valid_out  = 1'b0;
		cmd_out    = 3'h0;
		addr_out   = 2'h0;
		data_out   = 8'h00;
		fw_rd_out  = 1'b0;
		fw_ptr_out = 16'h0000;
	end

	// session level; latched copies settle one cycle after the change
	task automatic set_mode(input logic m, input logic hv);
		@(posedge clk_in);
		mode_out <= m;
		hv_out   <= hv;
		repeat (2) @(posedge clk_in);
		#1;
	endtask

	// one-cycle command; released lines flip so stale values never look valid
	task automatic send(input logic [2:0] c, input logic [1:0] a, input logic [7:0] d,
		output logic [7:0] rd, output logic rv, output logic rf);
		@(posedge clk_in);
		valid_out <= 1'b1;
		cmd_out   <= c;
		addr_out  <= a;
		data_out  <= d;
		@(posedge clk_in);
		valid_out <= 1'b0;
		addr_out  <= ~a;
		data_out  <= ~d;
		#1;
		rd = rdata_in;
		rv = rvalid_in;
		rf = refused_in;
	endtask

	task automatic fw_read(input logic [15:0] p, output logic [7:0] rd, output logic rv);
		@(posedge clk_in);
		fw_rd_out  <= 1'b1;
		fw_ptr_out <= p;
		@(posedge clk_in);
		fw_rd_out  <= 1'b0;
		fw_ptr_out <= ~p;
		#1;
		rd = fw_rdata_in;
		rv = fw_rvalid_in;
	endtask
endmodule

// ### tb/test_fuse_lock_config_unit.sv
`timescale 1ns/100ps
module test_fuse_lock_config_unit;
	import flc_pkg::*;
	logic        clk, nrst, sys_rst, cal_we;
	logic [7:0]  cal_wd, rd;
	logic [8:0]  pc;
	logic [5:0]  ea;
	logic        rv, rf;
	wire logic   mode, hv, vld, fwrd, rvalid, refused, fwrv, ef, ee, wr_ok, vfy_ok;
	wire logic   dbg_en, dbg_pm, ser_en, pres, wdt_irq, rc96, self_pe, ext_dis, wdt_on, div8;
	wire logic [2:0]  cmd;
	wire logic [1:0]  addr, clk_src, ebyte, bod, sut;
	wire logic [7:0]  data, rdata, fwdata, osc;
	wire logic [15:0] fwptr;
	wire logic [3:0]  word, epage;
	wire logic [4:0]  fpage;
	int          errors, total_checks, cycles;
	logic [7:0]  sig_exp [3] = '{8'h3c, 8'h4d, 8'h5e};

	flc_fuse_lock_unit #(.SIG_BYTE0(8'h3c), .SIG_BYTE1(8'h4d), .SIG_BYTE2(8'h5e)) uut (
		.REF_CLK_IN(clk), .NRST_IN(nrst), .SYS_RESET_IN(sys_rst), .PROG_MODE_IN(mode),
		.PROG_HV_IN(hv), .PROG_CMD_VALID_IN(vld), .PROG_CMD_IN(cmd), .PROG_ADDR_IN(addr),
		.PROG_DATA_IN(data), .PROG_RDATA_OUT(rdata), .PROG_RVALID_OUT(rvalid),
		.PROG_REFUSED_OUT(refused), .ERASE_FLASH_OUT(ef), .ERASE_EEPROM_OUT(ee),
		.PROG_MEM_WR_OK_OUT(wr_ok), .PROG_MEM_VERIFY_OK_OUT(vfy_ok), .FW_RD_IN(fwrd),
		.FW_PTR_IN(fwptr), .FW_RDATA_OUT(fwdata), .FW_RVALID_OUT(fwrv),
		.OSC_CAL_WE_IN(cal_we), .OSC_CAL_WDATA_IN(cal_wd), .OSC_CAL_OUT(osc),
		.SELF_PROG_EN_OUT(self_pe), .DEBUG_LINK_EN_OUT(dbg_en),
		.DEBUG_PM_READ_OUT(dbg_pm), .BROWNOUT_LEVEL_OUT(bod),
		.EXT_RESET_DIS_OUT(ext_dis), .SERIAL_PROG_EN_OUT(ser_en),
		.EEPROM_PRESERVE_OUT(pres), .WDT_ALWAYS_ON_OUT(wdt_on), .WDT_IRQ_EN_OUT(wdt_irq),
		.CLOCK_DIV8_OUT(div8), .STARTUP_SEL_OUT(sut), .CLOCK_SRC_OUT(clk_src),
		.CLK_RC_9M6_OUT(rc96), .FLASH_PC_IN(pc), .EEPROM_ADDR_IN(ea),
		.FLASH_WORD_INDEX_OUT(word), .FLASH_PAGE_INDEX_OUT(fpage),
		.EEPROM_BYTE_OUT(ebyte), .EEPROM_PAGE_OUT(epage));

	flc_prog_model pm (
		.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .refused_in(refused),
		.fw_rdata_in(fwdata), .fw_rvalid_in(fwrv), .mode_out(mode), .hv_out(hv),
		.valid_out(vld), .cmd_out(cmd), .addr_out(addr), .data_out(data),
		.fw_rd_out(fwrd), .fw_ptr_out(fwptr));

	always #50 clk = ~clk;

	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			$display("[FAIL] run time limit reached");
			wrap_up;
		end
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk1(input string n, input logic e, input logic g);
		chk(n, {7'h00, e}, {7'h00, g});
	endtask

	task automatic pwr(input logic [2:0] c, input logic [7:0] d, input logic exp_rf);
		pm.send(c, 2'h0, d, rd, rv, rf);
		chk1("refused", exp_rf, rf);
	endtask

	task automatic pchk(input string n, input logic [2:0] c, input logic [1:0] a,
		input logic [7:0] e);
		pm.send(c, a, 8'h00, rd, rv, rf);
		chk1("rvalid", 1'b1, rv);
		chk(n, e, rd);
	endtask

	task automatic fwchk(input string n, input logic [15:0] p, input logic [7:0] e);
		pm.fw_read(p, rd, rv);
		chk1("fw_rvalid", 1'b1, rv);
		chk(n, e, rd);
	endtask

	task automatic t_defaults;
		chk1("serial_en", 1'b1, ser_en);
		chk1("rc_9m6", 1'b1, rc96);
		chk1("wdt_irq", 1'b1, wdt_irq);
		chk1("dbg_en", 1'b0, dbg_en);
		chk1("self_prog", 1'b0, self_pe);
		chk1("ext_rst_dis", 1'b0, ext_dis);
		chk("brownout", 8'h03, {6'h00, bod});
		chk1("wdt_on", 1'b0, wdt_on);
		chk1("clock_div8", 1'b1, div8);
		chk("startup", 8'h02, {6'h00, sut});
		chk("osc_cal", 8'h80, osc);
		fwchk("fw_low", FW_PTR_FUSE_LOW, 8'h6a);
		fwchk("fw_lock", FW_PTR_LOCK, 8'hff);
		fwchk("fw_high", FW_PTR_FUSE_HIGH, 8'hff);
	endtask

	task automatic t_geom;
		@(posedge clk);
		pc <= 9'h1a5;
		ea <= 6'h2d;
		repeat (2) @(posedge clk);
		#1;
		chk("flash_word", 8'h05, {4'h0, word});
		chk("flash_page", 8'h1a, {3'h0, fpage});
		chk("ee_byte", 8'h01, {6'h00, ebyte});
		chk("ee_page", 8'h0b, {4'h0, epage});
	endtask

	task automatic t_latch;
		pwr(CMD_WR_FUSE_LOW, 8'h00, 1'b1);
		pm.set_mode(1'b1, 1'b1);
		pwr(CMD_WR_FUSE_HIGH, 8'h02, 1'b0);
		pwr(CMD_WR_FUSE_LOW, 8'h16, 1'b0);
		chk1("preserve", 1'b1, pres);
		chk1("pm_read", 1'b0, dbg_pm);
		chk1("wdt_irq", 1'b1, wdt_irq);
		pchk("rd_high", CMD_RD_FUSE_LOCK, SEL_FUSE_HIGH, 8'he2);
		pm.set_mode(1'b0, 1'b1);
		chk1("pm_read", 1'b1, dbg_pm);
		chk1("dbg_en", 1'b1, dbg_en);
		chk1("wdt_irq", 1'b0, wdt_irq);
		chk("clk_src", 8'h02, {6'h00, clk_src});
		chk1("self_prog", 1'b1, self_pe);
		chk1("ext_rst_dis", 1'b1, ext_dis);
		chk("brownout", 8'h01, {6'h00, bod});
		chk1("wdt_on", 1'b1, wdt_on);
		chk1("clock_div8", 1'b0, div8);
		chk("startup", 8'h01, {6'h00, sut});
		fwchk("fw_high", FW_PTR_FUSE_HIGH, 8'he2);
	endtask

	task automatic t_lock;
		// serial session: the serial-enable bit must survive the write
		pm.set_mode(1'b1, 1'b0);
		pwr(CMD_WR_FUSE_LOW, 8'h8a, 1'b0);
		pchk("rd_low", CMD_RD_FUSE_LOCK, SEL_FUSE_LOW, 8'h0a);
		pwr(CMD_WR_LOCK, 8'hfe, 1'b0);
		chk1("wr_ok", 1'b0, wr_ok);
		chk1("vfy_ok", 1'b1, vfy_ok);
		pwr(CMD_WR_FUSE_LOW, 8'h6a, 1'b1);
		pchk("rd_lock", CMD_RD_FUSE_LOCK, SEL_LOCK, 8'hfe);
		pm.set_mode(1'b0, 1'b0);
		chk1("dbg_en", 1'b0, dbg_en);
		chk1("pm_read", 1'b1, dbg_pm);
		fwchk("fw_lock", FW_PTR_LOCK, 8'hfe);
		pm.set_mode(1'b1, 1'b1);
		pwr(CMD_WR_LOCK, 8'hfd, 1'b0);
		chk1("vfy_ok", 1'b0, vfy_ok);
		pwr(CMD_WR_FUSE_HIGH, 8'hff, 1'b1);
		pwr(CMD_WR_LOCK, 8'hff, 1'b0);
		pchk("rd_lock", CMD_RD_FUSE_LOCK, SEL_LOCK, 8'hfc);
		for (int i = 0; i < 3; i++)
			pchk("signature", CMD_RD_SIGNATURE, 2'(i), sig_exp[i]);
		pwr(CMD_CHIP_ERASE, 8'h00, 1'b0);
		chk1("erase_flash", 1'b1, ef);
		chk1("erase_eeprom", 1'b0, ee);
		pchk("rd_lock", CMD_RD_FUSE_LOCK, SEL_LOCK, 8'hff);
		pchk("rd_low", CMD_RD_FUSE_LOCK, SEL_FUSE_LOW, 8'h0a);
		chk1("wr_ok", 1'b1, wr_ok);
		pwr(CMD_WR_FUSE_LOW, 8'h4a, 1'b0);
		chk1("preserve", 1'b0, pres);
		pwr(CMD_CHIP_ERASE, 8'h00, 1'b0);
		chk1("erase_eeprom", 1'b1, ee);
		pwr(3'h7, 8'h00, 1'b1);
		pchk("rd_lock", CMD_RD_FUSE_LOCK, SEL_LOCK, 8'hff);
		pm.set_mode(1'b0, 1'b1);
		chk1("dbg_en", 1'b1, dbg_en);
	endtask

	task automatic t_osc;
		@(posedge clk);
		cal_we <= 1'b1;
		cal_wd <= 8'h33;
		@(posedge clk);
		cal_we <= 1'b0;
		#1;
		chk("osc_cal", 8'h33, osc);
		@(posedge clk);
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		#1;
		chk("osc_cal", 8'h80, osc);
	endtask

	initial
	begin
		clk = 1'b0;
		nrst = 1'b0;
		sys_rst = 1'b0;
		cal_we = 1'b0;
		cal_wd = 8'h00;
		pc = 9'h000;
		ea = 6'h00;
		errors = 0;
		total_checks = 0;
		cycles = 0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		t_defaults;
		t_geom;
		t_latch;
		t_lock;
		t_osc;
		wrap_up;
	end
endmodule
